// *** design/tla_alarm_top.sv ***
// What this block does
// RULE1: Over-limit alarm pin goes low when a temperature exceeds its high limit.
// RULE2: Critical output goes low above the critical limit, independent of the alarm.
// RULE3: Critical output releases only at critical limit minus hysteresis.
// RULE4: Hysteresis resets to ten degrees.
// RULE5: Alarm releases when below limit, alert response seen, and status cleared.
// RULE6: Shared pin works as over-limit alarm or second critical output.
// RULE7: Second critical output goes low when either channel exceeds its high limit.
// RULE8: Second critical output self-releases like the main one; mask ignored.
// RULE9: Second critical output uses the same hysteresis value.
// RULE10: Both channels are checked for both critical outputs; either asserts.
// RULE11: Configuration bit 4 set disables beta cancellation.
// RULE12: Signed offset register is added to every temperature result.
// RULE13: Configuration bit 7 suppresses alarm assertions when pin is the alarm.
// RULE14: Configuration bit 5 picks alarm (0) or second critical output (1).
// RULE15: Hysteresis register accepts zero to thirty-one degrees.
// RULE16: Open remote sensor at conversion start sets status bit 2 and alarm.
// RULE17: Comparisons are redone on every result write and every limit write.
`timescale 1ns/1ps
`default_nettype none
module tla_alarm_top
  import tla_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [AW-1:0]     i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DW-1:0]     i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [DW-1:0]          o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Conversion results
  input  wire logic              i_conv_valid,
  input  wire logic              i_conv_channel,
  input  wire logic [TEMP_W-1:0] i_conv_raw,
  input  wire logic              i_open_fault,
  // Alert response serviced by serial logic
  input  wire logic              i_alert_response,
  // Critical output pin, open drain
  input  wire logic              i_critical_temp_out_n,
  output logic                   o_critical_temp_out_n,
  output logic                   o_critical_temp_oe,
  // Shared alarm pin, open drain
  input  wire logic              i_shared_pin_n,
  output logic                   o_shared_pin_n,
  output logic                   o_shared_pin_oe,
  // Analog front-end controls
  output logic                   o_beta_cancel_dis,
  output logic                   o_ext_range,
  output logic                   o_standby,
  // Interrupt
  output logic                   o_irq
);
  // Saturating add keeps a corrected reading from wrapping sign
  function automatic logic [TEMP_W-1:0] add_offset(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] b);
    logic signed [8:0] s;
    s = $signed({a[TEMP_W-1], a}) + $signed({b[TEMP_W-1], b});
    if (s > $signed({1'b0, TEMP_MAX}))
      add_offset = TEMP_MAX;
    else if (s < $signed({1'b1, TEMP_MIN}))
      add_offset = TEMP_MIN;
    else
      add_offset = s[TEMP_W-1:0];
  endfunction : add_offset

  function automatic logic gt_s(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] b);
    gt_s = $signed(a) > $signed(b);
  endfunction : gt_s

  logic [7:0]        cfg_ff,       nxt_cfg;
  logic [ST_W-1:0]   status_ff,    nxt_status;
  logic [ST_W-1:0]   irq_mask_ff,  nxt_irq_mask;
  logic [HYST_W-1:0] hyst_ff,      nxt_hyst;
  logic [TEMP_W-1:0] offset_ff,    nxt_offset;
  logic [TEMP_W-1:0] high_ff [2];
  logic [TEMP_W-1:0] nxt_high [2];
  logic [TEMP_W-1:0] crit_ff [2];
  logic [TEMP_W-1:0] nxt_crit [2];
  logic [TEMP_W-1:0] temp_ff [2];
  logic [TEMP_W-1:0] nxt_temp [2];
  logic              ack_ff,       nxt_ack;
  logic [DW-1:0]     rdata_ff,     nxt_rdata;
  logic              eval_ff,      nxt_eval;
  logic              alert_ff,     nxt_alert;
  logic              crit_oe_ff,   nxt_crit_oe;
  logic              shared_oe_ff, nxt_shared_oe;
  logic              irq_ff,       nxt_irq;
  logic [2:0]        crit_sync_ff, shared_sync_ff;
  logic [1:0]        pin_lvl_ff,   nxt_pin_lvl;
  logic              wr_fire,      rd_fire,  limit_wr;
  logic [1:0]        high_over;
  logic [3:0]        cmp_active;
  logic [ST_W-1:0]   st_set,       st_clr;
  logic              crit_any,     crit2_any, alert_cause;

  // One wait cycle; the second cycle of a request completes it
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
  assign wr_fire  = i_avs_write & ack_ff & i_avs_byteenable[0];
  assign rd_fire  = i_avs_read & ~ack_ff;
  assign limit_wr = wr_fire & (i_avs_address == OFFS_LOCAL_HIGH || i_avs_address == OFFS_REMOTE_HIGH
                            || i_avs_address == OFFS_LOCAL_CRIT || i_avs_address == OFFS_REMOTE_CRIT);

  // Register writes, conversion capture
  always_comb
  begin
    nxt_ack      = (i_avs_read | i_avs_write) & ~ack_ff;
    nxt_cfg      = cfg_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_hyst     = hyst_ff;
    nxt_offset   = offset_ff;
    nxt_high     = high_ff;
    nxt_crit     = crit_ff;
    nxt_temp     = temp_ff;
    st_clr       = '0;
    if (wr_fire)
    begin
      unique case (i_avs_address)
        OFFS_CONFIG:      nxt_cfg = (i_avs_writedata[7:0] & CFG_WR_MASK) | (cfg_ff & ~CFG_WR_MASK);
        OFFS_STATUS:      st_clr = i_avs_writedata[ST_W-1:0];
        OFFS_IRQ_MASK:    nxt_irq_mask = i_avs_writedata[ST_W-1:0];
        OFFS_HYST:        nxt_hyst = i_avs_writedata[HYST_W-1:0];  // RULE15
        OFFS_OFFSET:      nxt_offset = i_avs_writedata[TEMP_W-1:0];
        OFFS_LOCAL_HIGH:  nxt_high[CH_LOCAL] = i_avs_writedata[TEMP_W-1:0];
        OFFS_REMOTE_HIGH: nxt_high[CH_REMOTE] = i_avs_writedata[TEMP_W-1:0];
        OFFS_LOCAL_CRIT:  nxt_crit[CH_LOCAL] = i_avs_writedata[TEMP_W-1:0];
        OFFS_REMOTE_CRIT: nxt_crit[CH_REMOTE] = i_avs_writedata[TEMP_W-1:0];
        default:          ;
      endcase
    end
    // Results still land in standby; the sequencer stops issuing them
    if (i_conv_valid)
      nxt_temp[i_conv_channel] = add_offset(i_conv_raw, offset_ff);  // RULE12
    nxt_eval = i_conv_valid | limit_wr;  // RULE17
  end

  // Read data captured on the wait cycle so it stands with waitrequest low
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (rd_fire)
    begin
      nxt_rdata = '0;
      unique case (i_avs_address)
        OFFS_CONFIG:      nxt_rdata[7:0] = cfg_ff;
        OFFS_STATUS:      nxt_rdata[ST_W-1:0] = status_ff;
        OFFS_IRQ_MASK:    nxt_rdata[ST_W-1:0] = irq_mask_ff;
        OFFS_HYST:        nxt_rdata[HYST_W-1:0] = hyst_ff;
        OFFS_OFFSET:      nxt_rdata[TEMP_W-1:0] = offset_ff;
        OFFS_LOCAL_HIGH:  nxt_rdata[TEMP_W-1:0] = high_ff[CH_LOCAL];
        OFFS_REMOTE_HIGH: nxt_rdata[TEMP_W-1:0] = high_ff[CH_REMOTE];
        OFFS_LOCAL_CRIT:  nxt_rdata[TEMP_W-1:0] = crit_ff[CH_LOCAL];
        OFFS_REMOTE_CRIT: nxt_rdata[TEMP_W-1:0] = crit_ff[CH_REMOTE];
        OFFS_LOCAL_TEMP:  nxt_rdata[TEMP_W-1:0] = temp_ff[CH_LOCAL];
        OFFS_REMOTE_TEMP: nxt_rdata[TEMP_W-1:0] = temp_ff[CH_REMOTE];
        OFFS_PIN_LEVEL:   nxt_rdata[1:0] = pin_lvl_ff;
        default:          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_ff      <= 1'b0;
      rdata_ff    <= '0;
      cfg_ff      <= CFG_RST;
      irq_mask_ff <= '0;
      hyst_ff     <= HYST_RST;  // RULE4
      offset_ff   <= OFFSET_RST;
      high_ff     <= '{LIMIT_RST, LIMIT_RST};
      crit_ff     <= '{LIMIT_RST, LIMIT_RST};
      temp_ff     <= '{OFFSET_RST, OFFSET_RST};
      eval_ff     <= 1'b0;
    end
    else
    begin
      ack_ff      <= nxt_ack;
      rdata_ff    <= nxt_rdata;
      cfg_ff      <= nxt_cfg;
      irq_mask_ff <= nxt_irq_mask;
      hyst_ff     <= nxt_hyst;
      offset_ff   <= nxt_offset;
      high_ff     <= nxt_high;
      crit_ff     <= nxt_crit;
      temp_ff     <= nxt_temp;
      eval_ff     <= nxt_eval;
    end
  end

  // Index 0..1 critical, 2..3 second critical on high limits
  for (genvar g = 0; g < 4; g++)
  begin : g_cmp
    tla_hyst_cmp u_cmp (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_eval    (eval_ff),
      .i_temp    (temp_ff[g % 2]),
      .i_limit   ((g < 2) ? crit_ff[g % 2] : high_ff[g % 2]),  // RULE7
      .i_hyst    (hyst_ff),  // RULE9
      .o_active  (cmp_active[g])
    );
  end

  // Alarm latch, status, pins
  always_comb
  begin
    high_over[CH_LOCAL]  = gt_s(temp_ff[CH_LOCAL], high_ff[CH_LOCAL]);  // RULE1
    high_over[CH_REMOTE] = gt_s(temp_ff[CH_REMOTE], high_ff[CH_REMOTE]);
    crit_any  = cmp_active[0] | cmp_active[1];  // RULE10
    crit2_any = cmp_active[2] | cmp_active[3];  // RULE10
    st_set = '0;
    st_set[ST_LOCAL_HIGH]  = eval_ff & high_over[CH_LOCAL];
    st_set[ST_REMOTE_HIGH] = eval_ff & high_over[CH_REMOTE];
    st_set[ST_OPEN]        = i_open_fault;  // RULE16
    st_set[ST_LOCAL_CRIT]  = cmp_active[0];
    st_set[ST_REMOTE_CRIT] = cmp_active[1];
    // Set beats a clear landing in the same cycle
    nxt_status = (status_ff & ~st_clr) | st_set;
    // Mask and pin mode gate new assertions, not a pending latch
    alert_cause = ~cfg_ff[CFG_MASK_BIT] & ~cfg_ff[CFG_SEL_BIT]  // RULE13
                & (st_set[ST_LOCAL_HIGH] | st_set[ST_REMOTE_HIGH] | i_open_fault);  // RULE1 RULE16
    nxt_alert = alert_ff;
    if (i_alert_response && ~|high_over && ~|(status_ff & ST_ALERT_SRC))
      nxt_alert = 1'b0;  // RULE5
    if (alert_cause)
      nxt_alert = 1'b1;
    nxt_crit_oe = crit_any;  // RULE2 RULE3
    if (cfg_ff[CFG_SEL_BIT])
      nxt_shared_oe = crit2_any;  // RULE6 RULE8 RULE14
    else
      nxt_shared_oe = alert_ff & ~cfg_ff[CFG_MASK_BIT];  // RULE13
    nxt_irq = |(status_ff & ~irq_mask_ff);
    // Only synchroniser stages two and three are looked at
    nxt_pin_lvl = pin_lvl_ff;
    if (crit_sync_ff[1] == crit_sync_ff[2])
      nxt_pin_lvl[0] = crit_sync_ff[2];
    if (shared_sync_ff[1] == shared_sync_ff[2])
      nxt_pin_lvl[1] = shared_sync_ff[2];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_ff      <= '0;
      alert_ff       <= 1'b0;
      crit_oe_ff     <= 1'b0;
      shared_oe_ff   <= 1'b0;
      irq_ff         <= 1'b0;
      crit_sync_ff   <= 3'h7;
      shared_sync_ff <= 3'h7;
      pin_lvl_ff     <= 2'h3;
    end
    else
    begin
      status_ff      <= nxt_status;
      alert_ff       <= nxt_alert;
      crit_oe_ff     <= nxt_crit_oe;
      shared_oe_ff   <= nxt_shared_oe;
      irq_ff         <= nxt_irq;
      crit_sync_ff   <= {crit_sync_ff[1:0], i_critical_temp_out_n};
      shared_sync_ff <= {shared_sync_ff[1:0], i_shared_pin_n};
      pin_lvl_ff     <= nxt_pin_lvl;
    end
  end

  // Open drain: only ever pulls low
  assign o_critical_temp_out_n = 1'b0;
  assign o_critical_temp_oe    = crit_oe_ff;
  assign o_shared_pin_n        = 1'b0;
  assign o_shared_pin_oe       = shared_oe_ff;
  assign o_beta_cancel_dis     = cfg_ff[CFG_BETA_BIT];  // RULE11
  assign o_ext_range           = cfg_ff[CFG_RANGE_BIT];
  assign o_standby             = cfg_ff[CFG_STOP_BIT];
  assign o_avs_readdata        = rdata_ff;
  assign o_irq                 = irq_ff;

  a_wait_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_avs_read || i_avs_write) && !ack_ff |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("Bus answer not one wait cycle");
  a_hyst_default: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE4
    $fell(i_rst) |-> hyst_ff == HYST_RST)
    else $error("Hysteresis not at default after reset");
  a_crit_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE2
    eval_ff && gt_s(temp_ff[CH_REMOTE], crit_ff[CH_REMOTE]) |=> ##1 o_critical_temp_oe)
    else $error("Critical output not driven above limit");
  a_alert_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE5
    $fell(alert_ff) |-> $past(i_alert_response) && $past(status_ff[ST_OPEN:0]) == 3'h0)
    else $error("Alarm released without service");
  a_alert_set: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE1
    eval_ff && (|high_over) && cfg_ff[CFG_SEL_BIT:CFG_SEL_BIT] == 1'b0
      && !cfg_ff[CFG_MASK_BIT] |=> ##1 o_shared_pin_oe)
    else $error("Alarm pin not driven after over-limit");
  a_mask_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE13
    cfg_ff[CFG_MASK_BIT] && !cfg_ff[CFG_SEL_BIT] |=> !o_shared_pin_oe)
    else $error("Masked alarm drove the pin");
  a_crit2_mode: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE7
    cfg_ff[CFG_SEL_BIT] && (cmp_active[2] || cmp_active[3]) |=> o_shared_pin_oe)
    else $error("Second critical output not driven");
  a_open_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE16
    i_open_fault |=> status_ff[ST_OPEN])
    else $error("Open fault flag not set");
  a_offset_add: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE12
    i_conv_valid && !wr_fire |=> temp_ff[$past(i_conv_channel)] == add_offset($past(i_conv_raw), offset_ff))
    else $error("Offset not applied to result");
  a_eval_limit: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE17
    limit_wr |=> eval_ff)
    else $error("Limit write did not re-evaluate");
  c_alert_on: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(alert_ff));
  c_alert_off: cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(alert_ff));
  c_crit_cycle: cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(o_critical_temp_oe));
  c_crit2: cover property (@(posedge i_sys_clk) disable iff (i_rst) cfg_ff[CFG_SEL_BIT] && o_shared_pin_oe);
endmodule : tla_alarm_top
`default_nettype wire

// *** design/tla_hyst_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module tla_hyst_cmp
  import tla_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Comparison inputs
  input  wire logic              i_eval,
  input  wire logic [TEMP_W-1:0] i_temp,
  input  wire logic [TEMP_W-1:0] i_limit,
  input  wire logic [HYST_W-1:0] i_hyst,
  // Result
  output logic                   o_active
);
  logic              active_ff;
  logic              nxt_active;
  logic signed [8:0] temp_s;
  logic signed [8:0] limit_s;
  logic signed [8:0] release_s;

  // Widened so limit minus hysteresis cannot wrap
  always_comb
  begin
    temp_s    = $signed({i_temp[TEMP_W-1], i_temp});
    limit_s   = $signed({i_limit[TEMP_W-1], i_limit});
    release_s = limit_s - $signed({4'h0, i_hyst});
    nxt_active = active_ff;
    if (i_eval)
    begin
      if (temp_s > limit_s)
        nxt_active = 1'b1;  // RULE2
      else if (temp_s <= release_s)
        nxt_active = 1'b0;  // RULE3
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      active_ff <= 1'b0;
    else
      active_ff <= nxt_active;
  end

  assign o_active = active_ff;

  a_trip_above: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE2
    i_eval && (temp_s > limit_s) |=> o_active)
    else $error("Comparator did not trip above limit");
  a_release_band: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE3
    o_active && !i_eval |=> o_active)
    else $error("Comparator released without evaluation");
  a_release_level: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE3
    i_eval && (temp_s <= release_s) && !(temp_s > limit_s) |=> !o_active)
    else $error("Comparator held below release level");
endmodule : tla_hyst_cmp
`default_nettype wire

// *** design/tla_pkg.sv ***
package tla_pkg;
  localparam int TEMP_W = 8;
  localparam int HYST_W = 5;
  localparam int AW     = 8;
  localparam int DW     = 32;

  // Channel indices
  localparam int CH_LOCAL  = 0;
  localparam int CH_REMOTE = 1;

  // Register byte offsets
  localparam logic [AW-1:0] OFFS_CONFIG      = 8'h00;
  localparam logic [AW-1:0] OFFS_STATUS      = 8'h04;
  localparam logic [AW-1:0] OFFS_IRQ_MASK    = 8'h08;
  localparam logic [AW-1:0] OFFS_HYST        = 8'h0c;
  localparam logic [AW-1:0] OFFS_OFFSET      = 8'h10;
  localparam logic [AW-1:0] OFFS_LOCAL_HIGH  = 8'h14;
  localparam logic [AW-1:0] OFFS_REMOTE_HIGH = 8'h18;
  localparam logic [AW-1:0] OFFS_LOCAL_CRIT  = 8'h1c;
  localparam logic [AW-1:0] OFFS_REMOTE_CRIT = 8'h20;
  localparam logic [AW-1:0] OFFS_LOCAL_TEMP  = 8'h24;
  localparam logic [AW-1:0] OFFS_REMOTE_TEMP = 8'h28;
  localparam logic [AW-1:0] OFFS_PIN_LEVEL   = 8'h2c;

  // Configuration fields
  localparam int CFG_MASK_BIT  = 7;
  localparam int CFG_STOP_BIT  = 6;
  localparam int CFG_SEL_BIT   = 5;
  localparam int CFG_BETA_BIT  = 4;
  localparam int CFG_RANGE_BIT = 2;
  localparam logic [7:0] CFG_RST     = 8'h08;
  localparam logic [7:0] CFG_WR_MASK = 8'hf4;

  // Status fields, sticky, write one to clear
  localparam int ST_LOCAL_HIGH  = 0;
  localparam int ST_REMOTE_HIGH = 1;
  localparam int ST_OPEN        = 2;
  localparam int ST_LOCAL_CRIT  = 3;
  localparam int ST_REMOTE_CRIT = 4;
  localparam int ST_W           = 5;
  localparam logic [ST_W-1:0] ST_ALERT_SRC = 5'h07;

  // Reset values and saturation bounds
  localparam logic [HYST_W-1:0] HYST_RST   = 5'h0a;
  localparam logic [TEMP_W-1:0] LIMIT_RST  = 8'h55;
  localparam logic [TEMP_W-1:0] OFFSET_RST = 8'h00;
  localparam logic [TEMP_W-1:0] TEMP_MAX   = 8'h7f;
  localparam logic [TEMP_W-1:0] TEMP_MIN   = 8'h80;
endpackage : tla_pkg

// *** verification/tla_alarm_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tla_alarm_top_tb;
  import tla_pkg::*;
  logic              clk, rst, rd, wr, conv_v, conv_ch, open_f, ara_req, ara;
  logic [AW-1:0]     addr;
  logic [DW-1:0]     wdata, rdata, got;
  logic [3:0]        be;
  logic [TEMP_W-1:0] raw;
  logic              wait_rq, crit_n, crit_oe, sh_n, sh_oe, beta, irq, crit_w, sh_w, rng, stby;
  int                bad_count, checks;

  tla_alarm_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_rq), .i_conv_valid(conv_v), .i_conv_channel(conv_ch),
    .i_conv_raw(raw), .i_open_fault(open_f), .i_alert_response(ara),
    .i_critical_temp_out_n(crit_w), .o_critical_temp_out_n(crit_n), .o_critical_temp_oe(crit_oe),
    .i_shared_pin_n(sh_w), .o_shared_pin_n(sh_n), .o_shared_pin_oe(sh_oe),
    .o_beta_cancel_dis(beta), .o_ext_range(rng), .o_standby(stby), .o_irq(irq));

  tla_host_model u_host (.i_sys_clk(clk), .i_rst(rst), .i_crit_data_n(crit_n), .i_crit_oe(crit_oe),
    .i_shared_data_n(sh_n), .i_shared_oe(sh_oe), .i_ara_req(ara_req), .o_crit_wire_n(crit_w),
    .o_shared_wire_n(sh_w), .o_alert_response(ara));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk32(input logic [DW-1:0] g, input logic [DW-1:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk32

  task automatic chk1(input logic g, input logic e, input string m);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %b", $time, m, g);
    end
  endtask : chk1

  // Holds the request until the rising edge that samples waitrequest low, releases there
  task automatic bus(input logic is_wr, input logic [AW-1:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    rd    <= ~is_wr;
    wr    <= is_wr;
    addr  <= a;
    wdata <= {24'h0, d};
    be    <= b;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_rq !== 1'b0 && n < 50);
    if (n >= 50)
      chk1(1'b1, 1'b0, "bus hang");
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [AW-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wreg

  task automatic rc(input logic [AW-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk32(got, {24'h0, e}, "register read");
  endtask : rc

  task automatic settle();
    repeat (5) @(negedge clk);
  endtask : settle

  task automatic conv(input logic ch, input logic [7:0] r);
    @(posedge clk);
    conv_v  <= 1'b1;
    conv_ch <= ch;
    raw     <= r;
    @(posedge clk);
    conv_v <= 1'b0;
    settle();
  endtask : conv

  task automatic open_pulse();
    @(posedge clk);
    open_f <= 1'b1;
    @(posedge clk);
    open_f <= 1'b0;
    settle();
  endtask : open_pulse

  task automatic answer();
    @(posedge clk);
    ara_req <= 1'b1;
    @(posedge clk);
    ara_req <= 1'b0;
    settle();
  endtask : answer

  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end

  initial
  begin
    bad_count = 0;
    checks    = 0;
    {rd, wr, conv_v, conv_ch, open_f, ara_req} = 6'h00;
    addr  = 8'h00;
    wdata = 32'h0;
    be    = 4'h0;
    raw   = 8'h00;
    rst   = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and an unmapped place
    rc(OFFS_CONFIG, 8'h08);
    rc(OFFS_HYST, 8'h0a);
    rc(OFFS_LOCAL_CRIT, 8'h55);
    rc(OFFS_STATUS, 8'h00);
    rc(8'h30, 8'h00);
    wreg(OFFS_CONFIG, 8'h57);
    settle();
    chk1(beta, 1'b1, "beta disable");
    chk1(rng, 1'b1, "range select");
    chk1(stby, 1'b1, "standby");
    rc(OFFS_CONFIG, 8'h5c);
    // Signed correction, with saturation at the bottom
    wreg(OFFS_OFFSET, 8'hfb);
    conv(1'b0, 8'h10);
    rc(OFFS_LOCAL_TEMP, 8'h0b);
    conv(1'b0, 8'h80);
    rc(OFFS_LOCAL_TEMP, 8'h80);
    wreg(OFFS_OFFSET, 8'h00);
    // Remote 90 trips alarm and critical
    conv(1'b1, 8'h5a);
    chk1(sh_oe, 1'b1, "alarm set");
    chk1(crit_oe, 1'b1, "critical set");
    chk1(irq, 1'b1, "irq raised");
    rc(OFFS_STATUS, 8'h12);
    rc(OFFS_PIN_LEVEL, 8'h00);
    rc(OFFS_REMOTE_TEMP, 8'h5a);
    answer();
    chk1(sh_oe, 1'b1, "alarm held while hot");
    conv(1'b1, 8'h50);
    chk1(crit_oe, 1'b1, "critical inside hysteresis");
    answer();
    chk1(sh_oe, 1'b1, "alarm held, status set");
    wreg(OFFS_STATUS, 8'h1f);
    rc(OFFS_STATUS, 8'h10);
    answer();
    chk1(sh_oe, 1'b0, "alarm released");
    conv(1'b1, 8'h4b);
    chk1(crit_oe, 1'b0, "critical released");
    wreg(OFFS_STATUS, 8'h1f);
    settle();
    chk1(irq, 1'b0, "irq cleared");
    // Open sensor, then the same event under the irq mask
    open_pulse();
    chk1(sh_oe, 1'b1, "open alarm");
    rc(OFFS_STATUS, 8'h04);
    wreg(OFFS_STATUS, 8'h04);
    answer();
    chk1(sh_oe, 1'b0, "open alarm released");
    wreg(OFFS_IRQ_MASK, 8'h1f);
    open_pulse();
    chk1(irq, 1'b0, "irq masked");
    rc(OFFS_IRQ_MASK, 8'h1f);
    wreg(OFFS_STATUS, 8'h1f);
    answer();
    wreg(OFFS_IRQ_MASK, 8'h00);
    // Alarm mask in alarm mode
    wreg(OFFS_CONFIG, 8'h80);
    conv(1'b1, 8'h5a);
    chk1(sh_oe, 1'b0, "masked alarm");
    rc(OFFS_STATUS, 8'h12);
    conv(1'b1, 8'h40);
    wreg(OFFS_STATUS, 8'h1f);
    // Second critical output, mask set but ignored
    wreg(OFFS_CONFIG, 8'ha0);
    wreg(OFFS_LOCAL_HIGH, 8'h32);
    conv(1'b0, 8'h3c);
    chk1(sh_oe, 1'b1, "second critical set");
    chk1(crit_oe, 1'b0, "critical untouched");
    conv(1'b0, 8'h2d);
    chk1(sh_oe, 1'b1, "second critical in hysteresis");
    conv(1'b0, 8'h28);
    chk1(sh_oe, 1'b0, "second critical self release");
    wreg(OFFS_LOCAL_HIGH, 8'h20);
    settle();
    chk1(sh_oe, 1'b1, "limit write re-evaluates");
    wreg(OFFS_LOCAL_HIGH, 8'h55);
    settle();
    chk1(sh_oe, 1'b0, "limit write releases");
    // Remote limits written while the remote reading is 64
    wreg(OFFS_REMOTE_CRIT, 8'h3c);
    wreg(OFFS_REMOTE_HIGH, 8'h3c);
    settle();
    chk1(crit_oe, 1'b1, "remote critical limit write");
    chk1(sh_oe, 1'b1, "remote second critical");
    rc(OFFS_REMOTE_CRIT, 8'h3c);
    // Hysteresis range and a write with lane 0 off
    wreg(OFFS_HYST, 8'hff);
    rc(OFFS_HYST, 8'h1f);
    bus(1'b1, OFFS_HYST, 8'h00, 4'he);
    rc(OFFS_HYST, 8'h1f);
    wreg(OFFS_HYST, 8'h00);
    rc(OFFS_HYST, 8'h00);
    conclude();
  end
endmodule : tla_alarm_top_tb
`default_nettype wire

// *** verification/tla_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tla_host_model
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // Open drain drivers of the device
  input  wire logic i_crit_data_n,
  input  wire logic i_crit_oe,
  input  wire logic i_shared_data_n,
  input  wire logic i_shared_oe,
  // Host wants to send the alert response address
  input  wire logic i_ara_req,
  // Resolved wire levels, pulled up when released
  output logic      o_crit_wire_n,
  output logic      o_shared_wire_n,
  // Device answered the alert response
  output logic      o_alert_response
);
  logic alert_response_ff;

  assign o_crit_wire_n    = i_crit_oe ? i_crit_data_n : 1'b1;
  assign o_shared_wire_n  = i_shared_oe ? i_shared_data_n : 1'b1;
  assign o_alert_response = alert_response_ff;

  // Host only runs the alert response while the shared line is low
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      alert_response_ff <= 1'b0;
    else
      alert_response_ff <= i_ara_req & ~o_shared_wire_n;
  end
endmodule : tla_host_model
`default_nettype wire
